// >>> src/sps_defs.svh
// Constants of the pipelined synchronous static RAM port
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH
`define SPS_ADDR_W 8
`define SPS_DEPTH 256
`define SPS_LANES 4
`define SPS_LANE_W 8
`define SPS_PAR_EN 1
`define SPS_BURST_W 2
`define SPS_LANE_MASK_ALL 4'hF
`endif

// >>> src/sps_pkg.sv
// Types of the pipelined synchronous static RAM port
`include "sps_defs.svh"
package sps_pkg;
    typedef enum logic [1:0] {
        SPS_IDLE = 2'b00,
        SPS_READ = 2'b01,
        SPS_WRITE = 2'b10
    } sps_cycle_t;
    typedef logic [`SPS_ADDR_W-1:0] sps_addr_t;
    typedef logic [`SPS_LANES-1:0] sps_lane_t;
    typedef logic [`SPS_LANES*`SPS_LANE_W-1:0] sps_data_t;
endpackage

// >>> src/sps_burst_step.sv
// Next address of a burst, linear or interleaved
`timescale 1ns/1ns
`default_nettype none
`include "sps_defs.svh"
module sps_burst_step (
    input wire logic [`SPS_ADDR_W-1:0] base,
    input wire logic [`SPS_BURST_W-1:0] count,
    input wire logic interleaved,
    output logic [`SPS_ADDR_W-1:0] addr
);
    logic [`SPS_BURST_W-1:0] low;
    always_comb begin
        if (interleaved) begin
            low = base[`SPS_BURST_W-1:0] ^ count;
        end else begin
            low = base[`SPS_BURST_W-1:0] + count;
        end
        addr = {base[`SPS_ADDR_W-1:`SPS_BURST_W], low};
    end
endmodule // sps_burst_step
`default_nettype wire

// >>> src/sps_port.sv
// Device side of a pipelined synchronous static RAM port
`timescale 1ns/1ns
`default_nettype none
`include "sps_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Inputs sampled at rising clock edge, except output enable, snooze and reset
// - Each byte enable writes its lane only
// - Enable a..d govern lanes and parity a..d
// - Parity only in parity organisations
// - Clock enable high freezes all edge updates, drive gating stays live
// - Read/write select counts only on loads
// - Direction changes only via new load
// - All enables low write full width
// - Chip enables sampled only on loads
// - Selected only with both lows, high high
// - Snooze enters standby, array kept
// - Snooze ignores all other inputs except reset
// - Output enable gates drivers asynchronously
// - Advance steps burst counter, load loads
// - Burst order: low linear, high interleaved
module sps_port (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable_n,
    input wire logic snooze_request,
    input wire logic output_enable_n,
    input wire logic load_or_advance,
    input wire logic read_write_n,
    input wire logic burst_order_select,
    input wire logic chip_enable_n,
    input wire logic chip_enable_second_n,
    input wire logic chip_enable_high,
    input wire sps_pkg::sps_addr_t sync_address_in,
    input wire logic lane_a_write_en_n,
    input wire logic lane_b_write_en_n,
    input wire logic lane_c_write_en_n,
    input wire logic lane_d_write_en_n,
    input wire sps_pkg::sps_data_t data_in,
    input wire sps_pkg::sps_lane_t parity_in,
    output sps_pkg::sps_data_t data_out,
    output sps_pkg::sps_lane_t parity_out,
    output logic data_oe_n
);
    import sps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        sps_cycle_t cyc;
        sps_addr_t base;
        logic [`SPS_BURST_W-1:0] count;
        sps_cycle_t out_cyc;
        sps_data_t rd_data;
        sps_lane_t rd_par;
    } sps_state_t;

    sps_state_t st;
    sps_state_t next_st;
    sps_addr_t cur_addr;
    sps_addr_t step_base;
    logic [`SPS_BURST_W-1:0] step_count;
    wire sps_data_t rd_word;
    wire sps_lane_t rd_pbit;
    sps_lane_t lane_we;
    logic live;
    logic loading;
    logic selected;

    function automatic logic lane_hit(input sps_lane_t en, input int i);
        return en[i];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address of this edge, worked out apart from the state copy to keep the loop open
    always_comb begin
        if (!load_or_advance) begin
            step_base = sync_address_in;
            step_count = '0;
        end else begin
            step_base = st.base;
            step_count = st.count + 1'b1;
        end
    end

    sps_burst_step u_step (
        .base(step_base),
        .count(step_count),
        .interleaved(burst_order_select),
        .addr(cur_addr)
    );

    always_comb begin
        live = !clock_enable_n && !snooze_request;
        loading = !load_or_advance;
        selected = !chip_enable_n && !chip_enable_second_n && chip_enable_high;
        // Enables low: is the controller's job, we only obey
        lane_we = ~{lane_d_write_en_n, lane_c_write_en_n, lane_b_write_en_n,
            lane_a_write_en_n};
        next_st = st;
        if (loading) begin
            next_st.base = sync_address_in;
            next_st.count = '0;
            if (!selected) begin
                next_st.cyc = SPS_IDLE;
            end else if (read_write_n) begin
                next_st.cyc = SPS_READ;
            end else begin
                next_st.cyc = SPS_WRITE;
            end
        end else begin
            // Advance keeps the loaded direction
            next_st.count = st.count + 1'b1;
        end
        next_st.out_cyc = next_st.cyc;
        next_st.rd_data = rd_word;
        next_st.rd_par = `SPS_PAR_EN ? rd_pbit : '0;
        if (!live) begin
            next_st = st;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array has no reset so snooze and reset never disturb contents
    // One array per lane, so each lane has a single writing process
    for (genvar i = 0; i < `SPS_LANES; i++) begin : g_lane
        logic [`SPS_LANE_W-1:0] lane_mem [`SPS_DEPTH];
        logic lane_par [`SPS_DEPTH];
        always_ff @(posedge clock) begin
            if (live && next_st.cyc == SPS_WRITE && lane_hit(lane_we, i)) begin
                lane_mem[cur_addr] <= data_in[i*`SPS_LANE_W +: `SPS_LANE_W];
                if (`SPS_PAR_EN) begin
                    lane_par[cur_addr] <= parity_in[i];
                end
            end
        end
        assign rd_word[i*`SPS_LANE_W +: `SPS_LANE_W] = lane_mem[cur_addr];
        assign rd_pbit[i] = lane_par[cur_addr];
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        data_out = st.rd_data;
        parity_out = st.rd_par;
        // Asynchronous gating: no clock in this path
        data_oe_n = output_enable_n || snooze_request || st.out_cyc != SPS_READ;
    end
endmodule // sps_port
`default_nettype wire

// >>> dv/sps_port_asserts.sv
// Drive-control assertions of the RAM port
`timescale 1ns/1ns
`default_nettype none
module sps_port_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable_n,
    input wire logic snooze_request,
    input wire logic output_enable_n,
    input wire logic load_or_advance,
    input wire logic read_write_n,
    input wire logic chip_enable_n,
    input wire logic chip_enable_second_n,
    input wire logic chip_enable_high,
    input wire logic data_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire go = !clock_enable_n && !snooze_request;
    wire ld = go && !load_or_advance;
    wire on = !output_enable_n && !snooze_request;
    wire sel = !chip_enable_n && !chip_enable_second_n && chip_enable_high;
    sequence rd; ld && sel && read_write_n; endsequence
    sequence wr; ld && sel && !read_write_n; endsequence
    sequence adv; go && load_or_advance; endsequence
    AST_OE: assert property (output_enable_n |-> data_oe_n) else $error("oe");
    AST_ZZ: assert property (snooze_request |-> data_oe_n) else $error("zz");
    AST_RD: assert property (rd ##1 on |-> !data_oe_n) else $error("rd");
    AST_WR: assert property (wr |=> data_oe_n) else $error("wr");
    AST_DS: assert property (ld && !sel |=> data_oe_n) else $error("ds");
    AST_ADV: assert property (rd ##1 adv ##1 on |-> !data_oe_n) else $error("adv");
    AST_WADV: assert property (wr ##1 adv |=> data_oe_n) else $error("wadv");
    AST_HOLD: assert property (clock_enable_n ##1 $stable({output_enable_n, snooze_request})
        |-> $stable(data_oe_n)) else $error("hold");
endmodule // sps_port_chk
bind sps_port sps_port_chk chk_u (.*);
`default_nettype wire

// >>> dv/sps_ctl_model.sv
// Memory controller model driving the port pins
`timescale 1ns/1ns
`default_nettype none
module sps_ctl_model (
    output logic clock_enable_n,
    output logic snooze_request,
    output logic output_enable_n,
    output logic load_or_advance,
    output logic read_write_n,
    output logic chip_enable_n,
    output logic chip_enable_second_n,
    output logic chip_enable_high,
    output sps_pkg::sps_addr_t sync_address_in,
    output logic lane_a_write_en_n,
    output logic lane_b_write_en_n,
    output logic lane_c_write_en_n,
    output logic lane_d_write_en_n,
    output sps_pkg::sps_data_t data_in,
    output sps_pkg::sps_lane_t parity_in
);
    // Caller changes pins only just after a rising edge
    task put(input logic [7:0] v, a, input logic [3:0] b, input logic [35:0] d);
        {clock_enable_n, snooze_request, output_enable_n, load_or_advance, read_write_n,
            chip_enable_n, chip_enable_second_n, chip_enable_high} = v;
        sync_address_in = a;
        {lane_d_write_en_n, lane_c_write_en_n, lane_b_write_en_n, lane_a_write_en_n} = b;
        {parity_in, data_in} = d;
    endtask
    initial put(0, 0, 4'hF, 0);
endmodule // sps_ctl_model
`default_nettype wire

// >>> dv/tb_top.sv
// Testbench of the RAM port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sps_pkg::*;
    logic clock = 0, reset = 1, burst_order_select = 0;
    logic clock_enable_n, snooze_request, output_enable_n, load_or_advance, read_write_n;
    logic chip_enable_n, chip_enable_second_n, chip_enable_high, data_oe_n;
    logic lane_a_write_en_n, lane_b_write_en_n, lane_c_write_en_n, lane_d_write_en_n;
    sps_addr_t sync_address_in;
    sps_data_t data_in, data_out;
    sps_lane_t parity_in, parity_out;
    logic [35:0] mem [256], q [$];
    logic [39:0] d;
    logic [7:0] lf = 8'h22, bad [4] = '{8'h00, 8'h03, 8'h05, 8'h41};
    int num_errors = 0, checks = 0;
    sps_port dut_u (.*);
    sps_ctl_model ctl_u (.*);
    always #50 clock = ~clock;
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    task chk(input string n, input logic [35:0] s, e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task end_of_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task c(input logic [7:0] v, a, input logic [3:0] b);
        @(posedge clock);
        d = {rnd(), rnd(), rnd(), rnd(), rnd()};
        #1 ctl_u.put(v, a, b, d[35:0]);
    endtask
    task wr(input logic [7:0] v, a, input logic [3:0] b);
        logic [35:0] m;
        m = {b, {8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        c(v, a, b);
        if (v == 8'h01) mem[a] = (mem[a] & m) | (d[35:0] & ~m);
    endtask
    // Burst with one stalled edge; linear wrap inside the low two address bits
    task rd(input logic [7:0] a);
        c(8'h09, a, 4'hF);
        q.push_back(mem[a]);
        for (int k = 1; k < 4; k++) begin
            c(k == 2 ? 8'h98 : 8'h18, rnd(), 4'hF);
            q.push_back(mem[{a[7:2], 2'(a[1:0] + (k + 1) / 2)}]);
        end
    endtask
    always @(posedge clock)
        if (data_oe_n === 1'b0)
            chk("rdata", {parity_out, data_out}, q.size() ? q.pop_front() : 'x);
    initial begin
        repeat (4) @(posedge clock);
        #1 reset = 0;
        for (int i = 0; i < 8; i++) wr(8'h01, 8'(i), 4'h0);
        for (int i = 0; i < 8; i++) wr(8'h01, 8'(i), 4'(rnd()));
        c(8'h19, 0, 4'hF);
        for (int i = 0; i < 4; i++) wr(bad[i], 8'(i), 4'h0);
        $display("writes done");
        rd(0);
        rd(6);
        // Output enable acts on the cycle after a read edge, so flush before hiding one
        c(8'h00, 0, 4'hF);
        c(8'h29, 3, 4'hF);
        c(8'h20, 0, 4'hF);
        rd(7);
        c(8'h00, 0, 4'hF);
        c(8'h00, 0, 4'hF);
        chk("left", 36'(q.size()), 0);
        $display("reads done");
        end_of_test();
    end
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
